// >>> logic/ddr3_access_device.sv
// Purpose: Device side of a DDR3 x16 link: command decode, banks, bursts, strobes
// Assumes: All link pins sampled by clk_sys through two flip-flops
// Notes:   Link pins resynchronised; array is a reduced window per bank
`default_nettype none

module ddr3_access_device
    import ddr3_access_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              linkClk,
    input  wire logic              memResetN,
    input  wire logic              clockEnable,
    input  wire logic              chipSelectN,
    input  wire logic              rowStrobeN,
    input  wire logic              colStrobeN,
    input  wire logic              writeEnableN,
    input  wire logic [BANK_W-1:0] bankSelectInputs,
    input  wire logic [ADDR_W-1:0] rowColumnAddressInputs,
    input  wire logic [BYTE_W-1:0] lowByteDataLinesIn,
    output logic      [BYTE_W-1:0] lowByteDataLinesOut,
    output logic                   lowByteDataLinesOe,
    input  wire logic [BYTE_W-1:0] highByteDataLinesIn,
    output logic      [BYTE_W-1:0] highByteDataLinesOut,
    output logic                   highByteDataLinesOe,
    input  wire logic              lowByteStrobeIn,
    input  wire logic              lowByteStrobeNIn,
    output logic                   lowByteStrobeOut,
    output logic                   lowByteStrobeNOut,
    output logic                   lowByteStrobeOe,
    input  wire logic              highByteStrobeIn,
    input  wire logic              highByteStrobeNIn,
    output logic                   highByteStrobeOut,
    output logic                   highByteStrobeNOut,
    output logic                   highByteStrobeOe
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pinMeta_reg;
    logic [PIN_W-1:0] pinSync_reg;
    always_ff @(posedge clk_sys) begin
        pinMeta_reg <= {linkClk, memResetN, clockEnable, chipSelectN, rowStrobeN, colStrobeN,
                        writeEnableN, bankSelectInputs, rowColumnAddressInputs,
                        highByteDataLinesIn, lowByteDataLinesIn, highByteStrobeNIn,
                        highByteStrobeIn, lowByteStrobeNIn, lowByteStrobeIn};
        pinSync_reg <= pinMeta_reg;
    end

    logic              ckSync;
    logic              resetSyncN;
    logic              ckeSync;
    logic [3:0]        cmdSync;
    logic [BANK_W-1:0] baSync;
    logic [ADDR_W-1:0] addrSync;
    logic [WORD_W-1:0] dqSync;
    logic [3:0]        strobeSync;
    assign {ckSync, resetSyncN, ckeSync, cmdSync, baSync, addrSync, dqSync, strobeSync} =
        pinSync_reg;

    logic devReset;
    assign devReset = !rstn || !resetSyncN;

    // ------------------------------------------------------------
    // Link clock edges and command decode
    // ------------------------------------------------------------
    logic ckPrev_reg;
    always_ff @(posedge clk_sys) begin
        ckPrev_reg <= rstn ? ckSync : 1'b0;
    end
    logic linkRise;
    logic linkEdge;
    assign linkRise = ckSync && !ckPrev_reg;
    assign linkEdge = ckSync != ckPrev_reg;

    cmd_t cmd;
    always_comb begin
        cmd = CMD_NOP;
        if (linkRise && ckeSync && !cmdSync[3]) begin
            case (cmdSync[2:0])
                3'h3:    cmd = CMD_ACT;
                3'h5:    cmd = CMD_RD;
                3'h4:    cmd = CMD_WR;
                3'h2:    cmd = CMD_PRE;
                3'h0:    cmd = CMD_MRS;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode register 0 and bank state
    // ------------------------------------------------------------
    logic [1:0]        burstMode_reg;
    logic              interleave_reg;
    logic [7:0]        bankOpen_reg;
    logic [ADDR_W-1:0] openRow_reg [8];

    always_ff @(posedge clk_sys) begin
        if (devReset) begin
            burstMode_reg  <= MR_BL_RESET;
            interleave_reg <= 1'b0;
        end else if (cmd == CMD_MRS && baSync == MR0_BANK) begin
            burstMode_reg  <= addrSync[MR_BL_LSB +: 2];
            interleave_reg <= addrSync[MR_BT_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (devReset) begin
            bankOpen_reg <= 8'h00;
        end else if (cmd == CMD_ACT) begin
            bankOpen_reg[baSync] <= 1'b1;
            openRow_reg[baSync]  <= addrSync;
        end else if (cmd == CMD_PRE) begin
            if (addrSync[AUTO_PRECHARGE_BIT]) begin
                bankOpen_reg <= 8'h00;
            end else begin
                bankOpen_reg[baSync] <= 1'b0;
            end
        end else if ((cmd == CMD_RD || cmd == CMD_WR) && addrSync[AUTO_PRECHARGE_BIT]) begin
            bankOpen_reg[baSync] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Burst descriptor taken with read or write
    // ------------------------------------------------------------
    logic [BANK_W-1:0]    burstBank_reg;
    logic [ROW_IDX_W-1:0] burstRow_reg;
    logic [COL_IDX_W-1:0] burstCol_reg;
    logic [3:0]           burstLen_reg;
    logic [3:0]           lenNext;
    always_comb begin
        case (burstMode_reg)
            BL_FIXED4:     lenNext = FOUR_BEAT_CHOPPED_BURST;
            BL_ON_THE_FLY: lenNext = addrSync[BURST_CHOP_BIT] ? EIGHT_BEAT_BURST
                                                              : FOUR_BEAT_CHOPPED_BURST;
            default:       lenNext = EIGHT_BEAT_BURST;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (devReset) begin
            burstLen_reg <= EIGHT_BEAT_BURST;
        end else if (cmd == CMD_RD || cmd == CMD_WR) begin
            burstBank_reg <= baSync;
            burstRow_reg  <= openRow_reg[baSync][ROW_IDX_W-1:0];
            burstCol_reg  <= addrSync[COL_IDX_W-1:0];
            burstLen_reg  <= lenNext;
        end
    end

    function automatic logic [MEM_IDX_W-1:0] memIdx(input logic [3:0] beat,
                                                    input logic [BANK_W-1:0] bank,
                                                    input logic [ROW_IDX_W-1:0] row,
                                                    input logic [COL_IDX_W-1:0] col,
                                                    input logic il);
        return {bank, row, col[COL_IDX_W-1:3], beatCol(col[2:0], beat[2:0], il)};
    endfunction : memIdx

    // ------------------------------------------------------------
    // Write capture, one strobe per lane
    // ------------------------------------------------------------
    logic [BYTE_W-1:0] memLane [LANES][MEM_DEPTH];
    logic [LANES-1:0]  laneArmed_reg;
    logic [LANES-1:0]  laneLevel_reg;
    logic [3:0]        laneBeat_reg [LANES];
    logic [LANES-1:0]  laneValid;
    logic [LANES-1:0]  laneHigh;
    logic [LANES-1:0]  laneTake;

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            laneValid[l] = strobeSync[2*l] ^ strobeSync[2*l+1];
            laneHigh[l]  = strobeSync[2*l] && !strobeSync[2*l+1];
            laneTake[l]  = laneArmed_reg[l] && laneValid[l] && laneHigh[l] != laneLevel_reg[l]
                           && (laneBeat_reg[l] != 4'h0 || laneHigh[l]);
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int l = 0; l < LANES; l++) begin
            if (devReset) begin
                laneArmed_reg[l] <= 1'b0;
                laneLevel_reg[l] <= 1'b0;
                laneBeat_reg[l]  <= 4'h0;
            end else begin
                if (laneValid[l]) begin
                    laneLevel_reg[l] <= laneHigh[l];
                end
                if (cmd == CMD_WR) begin
                    laneArmed_reg[l] <= 1'b1;
                    laneBeat_reg[l]  <= 4'h0;
                end else if (laneTake[l]) begin
                    memLane[l][memIdx(laneBeat_reg[l], burstBank_reg, burstRow_reg,
                                      burstCol_reg, interleave_reg)] <=
                        dqSync[l*BYTE_W +: BYTE_W];
                    laneBeat_reg[l] <= laneBeat_reg[l] + 4'h1;
                    if (laneBeat_reg[l] + 4'h1 == burstLen_reg) begin
                        laneArmed_reg[l] <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read fetch into the two-entry buffer
    // ------------------------------------------------------------
    logic [WORD_W-1:0] bufMem_reg [BUF_DEPTH];
    logic              bufWrPtr_reg;
    logic              bufRdPtr_reg;
    logic [1:0]        bufCount_reg;
    logic              bufInReady;
    logic              bufOutValid;
    logic              bufPush;
    logic              bufPop;
    logic              drainReady;
    logic              fetchActive_reg;
    logic [3:0]        fetchBeat_reg;
    logic [MEM_IDX_W-1:0] fetchIdx;

    assign bufInReady  = bufCount_reg != BUF_FULL;
    assign bufOutValid = bufCount_reg != 2'h0;
    assign bufPush     = fetchActive_reg && bufInReady;
    assign bufPop      = drainReady && bufOutValid;
    assign fetchIdx    = memIdx(fetchBeat_reg, burstBank_reg, burstRow_reg, burstCol_reg,
                                interleave_reg);

    always_ff @(posedge clk_sys) begin
        if (devReset || cmd == CMD_RD) begin
            fetchActive_reg <= cmd == CMD_RD && !devReset;
            fetchBeat_reg   <= 4'h0;
        end else if (bufPush) begin
            fetchBeat_reg <= fetchBeat_reg + 4'h1;
            if (fetchBeat_reg + 4'h1 == burstLen_reg) begin
                fetchActive_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (devReset || cmd == CMD_RD) begin
            bufWrPtr_reg <= 1'b0;
            bufRdPtr_reg <= 1'b0;
            bufCount_reg <= 2'h0;
        end else begin
            if (bufPush) begin
                bufMem_reg[bufWrPtr_reg] <= {memLane[1][fetchIdx], memLane[0][fetchIdx]};
                bufWrPtr_reg <= !bufWrPtr_reg;
            end
            if (bufPop) begin
                bufRdPtr_reg <= !bufRdPtr_reg;
            end
            bufCount_reg <= bufCount_reg + {1'b0, bufPush} - {1'b0, bufPop};
        end
    end

    // ------------------------------------------------------------
    // Read drive: data and strobe change on every link edge
    // ------------------------------------------------------------
    rd_state_t rdState_reg;
    logic [3:0] latCount_reg;
    logic [3:0] driveBeat_reg;
    logic       burstDone;
    assign burstDone  = driveBeat_reg == burstLen_reg;
    assign drainReady = linkEdge && !burstDone && ((rdState_reg == RD_LATENCY && linkRise
                        && latCount_reg == 4'h0) || rdState_reg == RD_BURST);

    always_ff @(posedge clk_sys) begin
        if (devReset) begin
            rdState_reg   <= RD_IDLE;
            latCount_reg  <= 4'h0;
            driveBeat_reg <= 4'h0;
        end else if (cmd == CMD_RD) begin
            rdState_reg   <= RD_LATENCY;
            latCount_reg  <= READ_LATENCY_CK - 4'h1;
            driveBeat_reg <= 4'h0;
        end else begin
            case (rdState_reg)
                RD_LATENCY: begin
                    if (linkRise) begin
                        if (latCount_reg == 4'h0) begin
                            rdState_reg   <= RD_BURST;
                            driveBeat_reg <= 4'h1;
                        end else begin
                            latCount_reg <= latCount_reg - 4'h1;
                        end
                    end
                end
                RD_BURST: begin
                    if (linkEdge) begin
                        if (burstDone) begin
                            rdState_reg <= RD_IDLE;
                        end else begin
                            driveBeat_reg <= driveBeat_reg + 4'h1;
                        end
                    end
                end
                default: rdState_reg <= RD_IDLE;
            endcase
        end
    end

    logic driveOn;
    logic [WORD_W-1:0] driveWord;
    assign driveWord = bufOutValid ? bufMem_reg[bufRdPtr_reg]
                                   : {highByteDataLinesOut, lowByteDataLinesOut};
    always_ff @(posedge clk_sys) begin
        if (devReset) begin
            driveOn              <= 1'b0;
            lowByteDataLinesOut  <= 8'h00;
            highByteDataLinesOut <= 8'h00;
            lowByteStrobeOut     <= 1'b0;
            highByteStrobeOut    <= 1'b0;
            lowByteStrobeNOut    <= 1'b1;
            highByteStrobeNOut   <= 1'b1;
        end else if (drainReady) begin
            driveOn              <= 1'b1;
            {highByteDataLinesOut, lowByteDataLinesOut} <= driveWord;
            lowByteStrobeOut     <= ckSync;
            highByteStrobeOut    <= ckSync;
            lowByteStrobeNOut    <= !ckSync;
            highByteStrobeNOut   <= !ckSync;
        end else if (linkEdge && rdState_reg != RD_BURST) begin
            driveOn <= 1'b0;
        end else if (linkEdge && burstDone) begin
            driveOn <= 1'b0;
        end
    end
    assign lowByteDataLinesOe  = driveOn;
    assign highByteDataLinesOe = driveOn;
    assign lowByteStrobeOe     = driveOn;
    assign highByteStrobeOe    = driveOn;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_lane_strobe_pair: assert property (@(posedge clk_sys) disable iff (!rstn)
        lowByteStrobeOe |-> lowByteStrobeOut != lowByteStrobeNOut
                            && highByteStrobeOut != highByteStrobeNOut)
        else $error("strobe pair not complementary");
    a_lane_drive_both: assert property (@(posedge clk_sys) disable iff (!rstn)
        lowByteDataLinesOe == lowByteStrobeOe && highByteDataLinesOe == highByteStrobeOe)
        else $error("data and strobe enables differ");
    a_read_edge_aligned: assert property (@(posedge clk_sys) disable iff (devReset)
        drainReady |=> lowByteStrobeOut == $past(ckSync) && lowByteDataLinesOe)
        else $error("read strobe not aligned with data");
    a_bank_row_taken: assert property (@(posedge clk_sys) disable iff (devReset)
        cmd == CMD_ACT |=> bankOpen_reg[$past(baSync)]
                           && openRow_reg[$past(baSync)] == $past(addrSync))
        else $error("active did not open bank and row");
    a_bank_of_burst: assert property (@(posedge clk_sys) disable iff (devReset)
        cmd == CMD_RD |=> burstBank_reg == $past(baSync))
        else $error("burst bank not from bank select");
    a_auto_precharge: assert property (@(posedge clk_sys) disable iff (devReset)
        (cmd == CMD_WR && addrSync[AUTO_PRECHARGE_BIT]) |=> !bankOpen_reg[$past(baSync)])
        else $error("auto precharge ignored");
    a_chop_length: assert property (@(posedge clk_sys) disable iff (devReset)
        (cmd == CMD_RD && burstMode_reg == BL_ON_THE_FLY) |=>
        burstLen_reg == ($past(addrSync[BURST_CHOP_BIT]) ? 4'h8 : 4'h4))
        else $error("on-the-fly chop length wrong");
    a_beat_on_edge: assert property (@(posedge clk_sys) disable iff (devReset)
        $changed(driveBeat_reg) && rdState_reg == RD_BURST && $past(rdState_reg) == RD_BURST
        |-> $past(linkEdge))
        else $error("beat advanced without link edge");
    a_burst_bound: assert property (@(posedge clk_sys) disable iff (devReset)
        (rdState_reg == RD_IDLE || driveBeat_reg <= burstLen_reg)
        && (!laneArmed_reg[0] || laneBeat_reg[0] <= burstLen_reg))
        else $error("burst ran past its length");
endmodule : ddr3_access_device

`default_nettype wire

// >>> logic/ddr3_access_pkg.sv
// Purpose: Shared constants, types and helpers for the memory access block
// Assumes: Link pins are sampled by the 100 MHz system clock
// Notes:   Array is reduced to a small window of rows and columns per bank
`default_nettype none

package ddr3_access_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int BANK_W    = 3;
    localparam int ADDR_W    = 15;
    localparam int BYTE_W    = 8;
    localparam int LANES     = 2;
    localparam int WORD_W    = BYTE_W * LANES;
    localparam int ROW_IDX_W = 2;
    localparam int COL_IDX_W = 6;
    localparam int MEM_IDX_W = BANK_W + ROW_IDX_W + COL_IDX_W;
    localparam int MEM_DEPTH = 1 << MEM_IDX_W;
    localparam int PIN_W     = 3 + 4 + BANK_W + ADDR_W + WORD_W + 2 * LANES;

    // ------------------------------------------------------------
    // Address bit positions
    // ------------------------------------------------------------
    localparam int AUTO_PRECHARGE_BIT = 10;
    localparam int BURST_CHOP_BIT     = 12;
    localparam int MR_BL_LSB          = 0;
    localparam int MR_BT_BIT          = 3;

    // ------------------------------------------------------------
    // Burst and mode values
    // ------------------------------------------------------------
    localparam logic [3:0]        EIGHT_BEAT_BURST       = 4'h8;
    localparam logic [3:0]        FOUR_BEAT_CHOPPED_BURST = 4'h4;
    localparam logic [1:0]        BL_FIXED8      = 2'h0;
    localparam logic [1:0]        BL_ON_THE_FLY  = 2'h1;
    localparam logic [1:0]        BL_FIXED4      = 2'h2;
    localparam logic [BANK_W-1:0] MR0_BANK       = 3'h0;
    localparam logic [1:0]        MR_BL_RESET    = 2'h0;
    localparam logic [3:0]        READ_LATENCY_CK = 4'h5;

    // ------------------------------------------------------------
    // Read buffer
    // ------------------------------------------------------------
    localparam int         BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL  = 2'h2;

    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS} cmd_t;
    typedef enum logic [1:0] {RD_IDLE, RD_LATENCY, RD_BURST} rd_state_t;

    // Column of a beat within a burst, sequential or interleaved
    function automatic logic [2:0] beatCol(input logic [2:0] start, input logic [2:0] beat,
                                           input logic interleave);
        logic [2:0] seqCol;
        seqCol = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
        return interleave ? (start ^ beat) : seqCol;
    endfunction : beatCol
endpackage : ddr3_access_pkg

`default_nettype wire

// >>> test/mem_ctl_model.sv
// Purpose: Controller model: link clock, power-up, commands, write bursts
// Assumes: Device samples link pins with its own clock
// Notes:   Command, bank and address pins change on falling link edges; counts scaled down
`default_nettype none
module mem_ctl_model
    import ddr3_access_pkg::*;
(
    output logic              linkClk,
    output logic              memResetN,
    output logic              clockEnable,
    output logic              chipSelectN,
    output logic [2:0]        cmdPins,
    output logic [BANK_W-1:0] bankPins,
    output logic [ADDR_W-1:0] addrPins,
    output logic [WORD_W-1:0] dataPins,
    output logic              strobePin
);
    timeunit 1ns;
    timeprecision 10ps;
    initial begin
        linkClk = 1'b0;
        forever #62.5 linkClk = ~linkClk;
    end
    initial begin
        memResetN = 1'b0;
        clockEnable = 1'b0;
        chipSelectN = 1'b1;
        cmdPins = 3'h7;
        bankPins = 3'h0;
        addrPins = 15'h0000;
        dataPins = 16'h0000;
        strobePin = 1'b0;
    end
    // One command for one link rise, then deselect with address flipped
    task issue(input logic [2:0] code, input logic [BANK_W-1:0] bank,
               input logic [ADDR_W-1:0] addr);
        @(negedge linkClk);
        chipSelectN <= 1'b0;
        cmdPins <= code;
        bankPins <= bank;
        addrPins <= addr;
        @(negedge linkClk);
        chipSelectN <= 1'b1;
        cmdPins <= 3'h7;
        bankPins <= ~bank;
        addrPins <= ~addr;
    endtask : issue
    task power_up();
        repeat (8) @(negedge linkClk);
        memResetN <= 1'b1;
        repeat (8) @(negedge linkClk);
        clockEnable <= 1'b1;
        repeat (4) @(negedge linkClk);
        issue(3'h0, 3'h2, 15'h0000);
        issue(3'h0, 3'h3, 15'h0000);
        issue(3'h0, 3'h1, 15'h0000);
        issue(3'h0, 3'h0, 15'h0100);
        issue(3'h6, 3'h0, 15'h0400);
        repeat (16) @(negedge linkClk);
    endtask : power_up
    // Eight beats, strobe edge centred in each data eye
    task write_burst(input logic [WORD_W-1:0] base);
        for (int i = 0; i < 8; i++) begin
            dataPins <= base + WORD_W'(i);
            #31.25 strobePin <= (i % 2 == 0);
            #31.25;
        end
        strobePin <= 1'b0;
        dataPins <= ~(base + 16'h0007);
    endtask : write_burst
endmodule : mem_ctl_model
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for the memory access device
// Assumes: Controller model drives the link, bench resolves shared pins
// Notes:   Data written at column 0 holds base plus column
`default_nettype none
module testbench
    import ddr3_access_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk_sys;
    logic              rstn;
    logic              linkClk, memResetN, clockEnable, chipSelectN, strobePin;
    logic [2:0]        cmdPins;
    logic [BANK_W-1:0] bankPins;
    logic [ADDR_W-1:0] addrPins;
    logic [WORD_W-1:0] dataPins;
    logic [7:0]        lowOut, highOut;
    logic              lowOe, highOe, lsOut, lsnOut, lsOe, hsOut, hsnOut, hsOe;
    int                badCount = 0;
    int                checked = 0;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    mem_ctl_model i_ctl (.linkClk(linkClk), .memResetN(memResetN), .clockEnable(clockEnable),
        .chipSelectN(chipSelectN), .cmdPins(cmdPins), .bankPins(bankPins),
        .addrPins(addrPins), .dataPins(dataPins), .strobePin(strobePin));
    ddr3_access_device i_dut (.clk_sys(clk_sys), .rstn(rstn), .linkClk(linkClk),
        .memResetN(memResetN), .clockEnable(clockEnable), .chipSelectN(chipSelectN),
        .rowStrobeN(cmdPins[2]), .colStrobeN(cmdPins[1]), .writeEnableN(cmdPins[0]),
        .bankSelectInputs(bankPins), .rowColumnAddressInputs(addrPins),
        .lowByteDataLinesIn(lowOe ? lowOut : dataPins[7:0]),
        .lowByteDataLinesOut(lowOut), .lowByteDataLinesOe(lowOe),
        .highByteDataLinesIn(highOe ? highOut : dataPins[15:8]),
        .highByteDataLinesOut(highOut), .highByteDataLinesOe(highOe),
        .lowByteStrobeIn(lsOe ? lsOut : strobePin),
        .lowByteStrobeNIn(lsOe ? lsnOut : ~strobePin),
        .lowByteStrobeOut(lsOut), .lowByteStrobeNOut(lsnOut), .lowByteStrobeOe(lsOe),
        .highByteStrobeIn(hsOe ? hsOut : strobePin),
        .highByteStrobeNIn(hsOe ? hsnOut : ~strobePin),
        .highByteStrobeOut(hsOut), .highByteStrobeNOut(hsnOut), .highByteStrobeOe(hsOe));
    task check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            badCount++;
        end
    endtask : check
    // Read a burst from column col and compare beats, strobes and release
    task read_burst(input logic [2:0] bank, input logic [5:0] col, input logic a12,
                    input int n, input logic il, input logic [15:0] base);
        logic [2:0] bb;
        logic [2:0] c;
        int         k;
        i_ctl.issue(3'h5, bank, {2'h0, a12, 6'h00, col});
        k = 0;
        while (lowOe !== 1'b1 && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (2) @(negedge clk_sys);
        for (int b = 0; b <= n; b++) begin
            bb = b[2:0];
            c = il ? (col[2:0] ^ bb) : {col[2] ^ bb[2], col[1:0] + bb[1:0]};
            if (b < n) begin
                check({highOut, lowOut}, base + {13'h0000, c});
                check({8'h00, lsOut, lsnOut, hsOut, hsnOut, lowOe, highOe, lsOe, hsOe},
                      {8'h00, ~bb[0], bb[0], ~bb[0], bb[0], 4'hF});
            end else begin
                check({12'h000, lowOe, highOe, lsOe, hsOe}, 16'h0000);
            end
            #62.5;
        end
    endtask : read_burst
    task mode_read(input logic [14:0] mr, input logic [5:0] col, input logic a12,
                   input int n, input logic il);
        i_ctl.issue(3'h0, 3'h0, mr);
        read_burst(3'h0, col, a12, n, il, 16'hA000);
    endtask : mode_read
    task print_verdict();
        $display("checks=%0d mismatches=%0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        badCount++;
        print_verdict();
    end
    initial begin
        rstn = 1'b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        i_ctl.power_up();
        i_ctl.issue(3'h3, 3'h0, 15'h4001);
        i_ctl.issue(3'h3, 3'h7, 15'h0002);
        i_ctl.issue(3'h4, 3'h0, 15'h1000);
        i_ctl.write_burst(16'hA000);
        i_ctl.issue(3'h4, 3'h7, 15'h1400);
        i_ctl.write_burst(16'h7000);
        read_burst(3'h0, 6'h05, 1'b1, 8, 1'b0, 16'hA000);
        i_ctl.issue(3'h3, 3'h7, 15'h0002);
        read_burst(3'h7, 6'h03, 1'b1, 8, 1'b0, 16'h7000);
        mode_read(15'h0001, 6'h06, 1'b0, 4, 1'b0);
        mode_read(15'h0002, 6'h02, 1'b1, 4, 1'b0);
        mode_read(15'h0009, 6'h05, 1'b1, 8, 1'b1);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
